// ### rtl/urhps_params.svh
// register offsets, bit positions and timing constants for the root hub port block
`ifndef URHPS_PARAMS_SVH
`define URHPS_PARAMS_SVH
`define URHPS_OFF_HUB 8'h50
`define URHPS_OFF_P1 8'h54
`define URHPS_OFF_P2 8'h58
`define URHPS_OFF_CTRL 8'h5c
`define URHPS_OFF_MASK 8'h60
`define URHPS_B_CLR_WAKE 31
`define URHPS_B_HUB_OCC 17
`define URHPS_B_SET_GPWR 16
`define URHPS_B_WAKE_EN 15
`define URHPS_B_HUB_OC 1
`define URHPS_B_CLR_GPWR 0
`define URHPS_B_RST_DONE 20
`define URHPS_B_OC_CHG 19
`define URHPS_B_RES_DONE 18
`define URHPS_B_EN_CHG 17
`define URHPS_B_CONN_CHG 16
`define URHPS_B_LOW_SPEED 9
`define URHPS_B_PWR 8
`define URHPS_B_RST 4
`define URHPS_B_OC_RESUME 3
`define URHPS_B_SUSP 2
`define URHPS_B_EN 1
`define URHPS_B_CONN 0
`define URHPS_B_IRQ_ROUTE 0
`define URHPS_B_PWR_MODE 1
`define URHPS_B_OC_MODE 2
`define URHPS_RESET_MS 10
`define URHPS_CLK_KHZ 50000
`define URHPS_RESUME_US 20000
`define URHPS_RESP_OKAY 2'b00
`define URHPS_RESP_SLVERR 2'b10
`endif

// ### rtl/urhps_pkg.sv
// types of the root hub port status block
package urhps_pkg;
  typedef enum logic [3:0] {
    URHPS_IDLE = 4'b0001,
    URHPS_RESET = 4'b0010,
    URHPS_SUSP = 4'b0100,
    URHPS_RESUME = 4'b1000
  } urhps_port_e;
  typedef struct packed {
    urhps_port_e st;
    logic [31:0] cnt;
    logic pwr;
    logic en;
    logic conn_q;
    logic oc_q;
    logic rst_done;
    logic oc_chg;
    logic res_done;
    logic en_chg;
    logic conn_chg;
  } urhps_port_s;
endpackage : urhps_pkg

// ### rtl/urhps_root_hub.sv
// root hub status, two port status/control registers and interrupt merge, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "urhps_params.svh"

// Overview of operation
// [RL1] write one clears remote wakeup enable
// [RL2] set global power powers unmasked ports
// [RL3] clear global power; local power reads zero
// [RL4] hub overcurrent only in global mode
// [RL5] port reset lasts 10 ms, then done flag
// [RL6] change flags clear by writing one
// [RL7] port overcurrent sets overcurrent change flag
// [RL8] resume finish sets suspend change flag
// [RL9] attach or detach sets connect change
// [RL10] low speed bit valid while connected
// [RL11] bit 9 powers off, bit 8 on
// [RL12] reset of disconnected port flags connect change
// [RL13] clear suspend resumes only when suspended
// [RL14] set suspend suspends, else connect change
// [RL15] suspend clears on resume, reset end, wake
// [RL16] enable set only by finished reset
// [RL17] hardware disables port on fault events
// [RL18] software enable write is ignored
// [RL19] bit 0 write disables; read connect state
// [RL20] two merged system interrupt lines
// [RL21] routing bit chooses normal or management
// [RL22] routing one selects management path
// [RL23] hardware disable sets enable change flag
// [RL24] reserved bits read zero, ignore writes
module urhps_root_hub
  import urhps_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = `URHPS_RESET_MS * `URHPS_CLK_KHZ,
  parameter int unsigned RESUME_CYCLES = `URHPS_RESUME_US / 1000 * `URHPS_CLK_KHZ
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] connect_state_i,
  input wire logic [1:0] low_speed_attached_i,
  input wire logic [1:0] port_overcurrent_i,
  input wire logic hub_overcurrent_i,
  input wire logic [1:0] port_error_i,
  input wire logic [1:0] remote_resume_i,
  input wire logic normal_irq_i,
  input wire logic ownership_change_i,
  input wire logic power_event_irq_i,
  output logic [1:0] port_power_o,
  output logic [1:0] port_reset_o,
  output logic [1:0] port_suspend_o,
  output logic [1:0] port_resume_o,
  output logic [1:0] port_enabled_o,
  output logic wakeup_enable_o,
  output logic host_irq_line0_o,
  output logic host_irq_line1_o
);

  typedef struct packed {
    urhps_port_s [1:0] port;
    logic wake_en;
    logic hub_occ;
    logic hub_oc_q;
    logic irq_route_select;
    logic pwr_mode;
    logic oc_mode;
    logic [1:0] port_power_mask;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq0;
    logic irq1;
  } urhps_state_s;

  urhps_state_s cur;
  urhps_state_s next_cur;
  logic wr_fire;
  logic [31:0] hub_rd;
  logic [31:0] port_rd [2];
  logic [31:0] ctrl_rd;

  // write channels accepted independently, response once both held
  assign s_axi_awready = !cur.aw_got && !cur.bvalid;
  assign s_axi_wready = !cur.w_got && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign wr_fire = cur.aw_got && cur.w_got && !cur.bvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;

  // readback images; unused positions are zero
  always_comb begin
    hub_rd = 32'h0; // [RL24]
    hub_rd[`URHPS_B_HUB_OCC] = cur.hub_occ;
    hub_rd[`URHPS_B_WAKE_EN] = cur.wake_en;
    hub_rd[`URHPS_B_HUB_OC] = cur.oc_mode ? 1'b0 : hub_overcurrent_i; // [RL4]
    ctrl_rd = 32'h0;
    ctrl_rd[`URHPS_B_IRQ_ROUTE] = cur.irq_route_select;
    ctrl_rd[`URHPS_B_PWR_MODE] = cur.pwr_mode;
    ctrl_rd[`URHPS_B_OC_MODE] = cur.oc_mode;
    for (int p = 0; p < 2; p++) begin
      port_rd[p] = 32'h0;
      port_rd[p][`URHPS_B_RST_DONE] = cur.port[p].rst_done;
      port_rd[p][`URHPS_B_OC_CHG] = cur.port[p].oc_chg;
      port_rd[p][`URHPS_B_RES_DONE] = cur.port[p].res_done;
      port_rd[p][`URHPS_B_EN_CHG] = cur.port[p].en_chg;
      port_rd[p][`URHPS_B_CONN_CHG] = cur.port[p].conn_chg;
      port_rd[p][`URHPS_B_LOW_SPEED] = connect_state_i[p] & low_speed_attached_i[p]; // [RL10]
      port_rd[p][`URHPS_B_PWR] = cur.port[p].pwr; // [RL11]
      port_rd[p][`URHPS_B_RST] = (cur.port[p].st == URHPS_RESET); // [RL5]
      port_rd[p][`URHPS_B_OC_RESUME] = port_overcurrent_i[p];
      port_rd[p][`URHPS_B_SUSP] = (cur.port[p].st == URHPS_SUSP) ||
                                  (cur.port[p].st == URHPS_RESUME);
      port_rd[p][`URHPS_B_EN] = cur.port[p].en;
      port_rd[p][`URHPS_B_CONN] = connect_state_i[p]; // [RL19]
    end
  end

  // whole next state: bus, hub bits, port machines, interrupts
  always_comb begin
    logic [31:0] wd;
    logic hub_wr;
    logic [1:0] port_wr;
    logic [1:0] gp_sel;
    logic dis;
    next_cur = cur;
    wd = cur.w_data;
    hub_wr = 1'b0;
    port_wr = 2'b00;
    gp_sel = 2'b00;
    dis = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    // partial strobes are ignored: hub and port bits are command or sticky bits, control and mask bits are plain settings
    if (wr_fire) begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = `URHPS_RESP_OKAY;
      if (cur.w_strb != 4'hf) begin
        next_cur.bresp = `URHPS_RESP_OKAY;
      end else if (cur.aw_addr == `URHPS_OFF_HUB) begin
        hub_wr = 1'b1;
      end else if (cur.aw_addr == `URHPS_OFF_P1) begin
        port_wr[0] = 1'b1;
      end else if (cur.aw_addr == `URHPS_OFF_P2) begin
        port_wr[1] = 1'b1;
      end else if (cur.aw_addr == `URHPS_OFF_CTRL) begin
        next_cur.irq_route_select = wd[`URHPS_B_IRQ_ROUTE];
        next_cur.pwr_mode = wd[`URHPS_B_PWR_MODE];
        next_cur.oc_mode = wd[`URHPS_B_OC_MODE];
      end else if (cur.aw_addr == `URHPS_OFF_MASK) begin
        next_cur.port_power_mask = wd[1:0];
      end else begin
        next_cur.bresp = `URHPS_RESP_SLVERR;
      end
    end
    // hub-wide write effects
    if (hub_wr && wd[`URHPS_B_CLR_WAKE]) begin
      next_cur.wake_en = 1'b0; // [RL1]
    end
    if (hub_wr && wd[`URHPS_B_WAKE_EN]) begin
      next_cur.wake_en = 1'b1;
    end
    if (hub_wr && wd[`URHPS_B_HUB_OCC]) begin
      next_cur.hub_occ = 1'b0;
    end
    next_cur.hub_oc_q = hub_overcurrent_i;
    if (!cur.oc_mode && (hub_overcurrent_i != cur.hub_oc_q)) begin
      next_cur.hub_occ = 1'b1; // set beats clear
    end
    gp_sel = cur.pwr_mode ? ~cur.port_power_mask : 2'b11;
    for (int p = 0; p < 2; p++) begin
      next_cur.port[p].conn_q = connect_state_i[p];
      next_cur.port[p].oc_q = port_overcurrent_i[p];
      // change flags: write one clears, then hardware sets win
      if (port_wr[p]) begin
        if (wd[`URHPS_B_RST_DONE]) next_cur.port[p].rst_done = 1'b0; // [RL6]
        if (wd[`URHPS_B_OC_CHG]) next_cur.port[p].oc_chg = 1'b0; // [RL6]
        if (wd[`URHPS_B_RES_DONE]) next_cur.port[p].res_done = 1'b0; // [RL6]
        if (wd[`URHPS_B_EN_CHG]) next_cur.port[p].en_chg = 1'b0; // [RL6]
        if (wd[`URHPS_B_CONN_CHG]) next_cur.port[p].conn_chg = 1'b0; // [RL6]
        if (wd[`URHPS_B_PWR]) next_cur.port[p].pwr = 1'b1; // [RL11]
        if (wd[`URHPS_B_LOW_SPEED]) next_cur.port[p].pwr = 1'b0; // [RL11]
        if (wd[`URHPS_B_CONN]) next_cur.port[p].en = 1'b0; // [RL19]
        // set-enable bit deliberately has no effect [RL18]
      end
      if (hub_wr && wd[`URHPS_B_SET_GPWR] && gp_sel[p]) begin
        next_cur.port[p].pwr = 1'b1; // [RL2]
      end
      if (hub_wr && wd[`URHPS_B_CLR_GPWR] && gp_sel[p]) begin
        next_cur.port[p].pwr = 1'b0; // [RL3]
      end
      if (connect_state_i[p] != cur.port[p].conn_q) begin
        next_cur.port[p].conn_chg = 1'b1; // [RL9]
      end
      if (port_overcurrent_i[p] && !cur.port[p].oc_q) begin
        next_cur.port[p].oc_chg = 1'b1; // [RL7]
      end
      // port sequencer
      case (cur.port[p].st)
        URHPS_IDLE: begin
          if (port_wr[p] && wd[`URHPS_B_RST]) begin
            if (connect_state_i[p]) begin
              next_cur.port[p].st = URHPS_RESET; // [RL5]
              next_cur.port[p].cnt = 32'h0;
            end else begin
              next_cur.port[p].conn_chg = 1'b1; // [RL12]
            end
          end else if (port_wr[p] && wd[`URHPS_B_SUSP]) begin
            if (connect_state_i[p]) begin
              next_cur.port[p].st = URHPS_SUSP; // [RL14]
            end else begin
              next_cur.port[p].conn_chg = 1'b1; // [RL14]
            end
          end
        end
        URHPS_RESET: begin
          next_cur.port[p].cnt = cur.port[p].cnt + 32'h1;
          if (cur.port[p].cnt == RESET_CYCLES - 1) begin
            next_cur.port[p].st = URHPS_IDLE; // [RL15]
            next_cur.port[p].rst_done = 1'b1; // [RL5]
            next_cur.port[p].en = connect_state_i[p]; // [RL16]
          end
        end
        URHPS_SUSP: begin
          if (port_wr[p] && wd[`URHPS_B_OC_RESUME]) begin
            next_cur.port[p].st = URHPS_RESUME; // [RL13]
            next_cur.port[p].cnt = 32'h0;
          end else if (remote_resume_i[p]) begin
            next_cur.port[p].st = URHPS_RESUME; // [RL15]
            next_cur.port[p].cnt = 32'h0;
          end
        end
        URHPS_RESUME: begin
          next_cur.port[p].cnt = cur.port[p].cnt + 32'h1;
          if (cur.port[p].cnt == RESUME_CYCLES - 1) begin
            next_cur.port[p].st = URHPS_IDLE; // [RL15]
            next_cur.port[p].res_done = 1'b1; // [RL8]
          end
        end
        default: begin
          next_cur.port[p].st = URHPS_IDLE;
        end
      endcase
      // hardware disable on faults overrides everything else
      dis = port_overcurrent_i[p] || !connect_state_i[p] || !next_cur.port[p].pwr ||
            port_error_i[p];
      if (dis) begin
        next_cur.port[p].en = 1'b0; // [RL17]
        if (cur.port[p].en) next_cur.port[p].en_chg = 1'b1; // [RL23]
      end
      if (!connect_state_i[p] || !next_cur.port[p].pwr) begin
        next_cur.port[p].st = URHPS_IDLE;
      end
    end
    // interrupt merge; ownership change only on the management path
    next_cur.irq0 = power_event_irq_i || normal_irq_i ||
                    (cur.irq_route_select && ownership_change_i); // [RL20] [RL21] [RL22]
    next_cur.irq1 = power_event_irq_i; // [RL20]
    // read channel
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = `URHPS_RESP_OKAY;
      if (s_axi_araddr == `URHPS_OFF_HUB) begin
        next_cur.rdata = hub_rd;
      end else if (s_axi_araddr == `URHPS_OFF_P1) begin
        next_cur.rdata = port_rd[0];
      end else if (s_axi_araddr == `URHPS_OFF_P2) begin
        next_cur.rdata = port_rd[1];
      end else if (s_axi_araddr == `URHPS_OFF_CTRL) begin
        next_cur.rdata = ctrl_rd;
      end else if (s_axi_araddr == `URHPS_OFF_MASK) begin
        next_cur.rdata = {30'h0, cur.port_power_mask};
      end else begin
        next_cur.rdata = 32'h0;
        next_cur.rresp = `URHPS_RESP_SLVERR;
      end
    end
  end

  // single state register, synchronous reset
  // reset image: ports idle, power off, routing to normal path [RL21]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cur <= '0;
      cur.port[0].st <= URHPS_IDLE;
      cur.port[1].st <= URHPS_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs to the port drivers
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      port_power_o[p] = cur.port[p].pwr;
      port_reset_o[p] = (cur.port[p].st == URHPS_RESET);
      port_suspend_o[p] = (cur.port[p].st == URHPS_SUSP);
      port_resume_o[p] = (cur.port[p].st == URHPS_RESUME);
      port_enabled_o[p] = cur.port[p].en;
    end
  end
  assign wakeup_enable_o = cur.wake_en;
  assign host_irq_line0_o = cur.irq0;
  assign host_irq_line1_o = cur.irq1;

  // reset lasts exactly RESET_CYCLES then raises done flag
  a_reset_length: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL5]
    $fell(port_reset_o[0]) && connect_state_i[0] && port_power_o[0] |->
      $past(cur.port[0].cnt) == RESET_CYCLES - 1)
    else $error("reset ended after wrong count");
  a_reset_done: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL5]
    $fell(port_reset_o[0]) && connect_state_i[0] && port_power_o[0] |->
      cur.port[0].rst_done && port_enabled_o[0])
    else $error("reset end without done flag or enable");
  a_enable_only_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL16]
    $rose(port_enabled_o[0]) |-> $past(port_reset_o[0]))
    else $error("port enabled without reset");
  a_disconnect_dis: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL17]
    !connect_state_i[0] |=> !port_enabled_o[0])
    else $error("disconnected port still enabled");
  a_conn_chg_set: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL9]
    connect_state_i[0] != $past(connect_state_i[0]) |=> cur.port[0].conn_chg)
    else $error("connect change not flagged");
  a_oc_chg_set: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL7]
    $rose(port_overcurrent_i[1]) |=> cur.port[1].oc_chg)
    else $error("overcurrent change not flagged");
  a_line1_pme: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL20]
    host_irq_line1_o == $past(power_event_irq_i))
    else $error("second line not power event");
  a_route_normal: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL22]
    !cur.irq_route_select && !normal_irq_i && !power_event_irq_i |=> !host_irq_line0_o)
    else $error("ownership change leaked to normal path");
  a_hub_oc_perport: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL4]
    cur.oc_mode |-> !hub_rd[`URHPS_B_HUB_OC])
    else $error("hub overcurrent shown in per-port mode");
  a_resume_done: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL8]
    $fell(port_resume_o[0]) && connect_state_i[0] && port_power_o[0] |->
      cur.port[0].res_done && !port_suspend_o[0])
    else $error("resume end without suspend change");

endmodule : urhps_root_hub
`default_nettype wire

// ### sim/urhps_usb_dev_model.sv
// usb devices standing on the two downstream ports
`timescale 1ns/1ps
`default_nettype none
module urhps_usb_dev_model (
  input wire logic clock_i,
  input wire logic [1:0] plug_i,
  input wire logic [1:0] low_speed_i,
  input wire logic [1:0] overcurrent_i,
  input wire logic [1:0] wake_i,
  input wire logic [1:0] port_power_i,
  input wire logic [1:0] port_suspend_i,
  output logic [1:0] connect_state_o,
  output logic [1:0] low_speed_o,
  output logic [1:0] overcurrent_o,
  output logic [1:0] remote_resume_o
);
  logic [1:0] float_q = 2'b00;
  logic [1:0] wake_q = 2'b00;
  // a device pulls its line up only while the port feeds it power
  assign connect_state_o = plug_i & port_power_i;
  // speed line floats with nothing attached, so it toggles
  assign low_speed_o = (connect_state_o & low_speed_i) | (~connect_state_o & float_q);
  assign overcurrent_o = overcurrent_i;
  // resume signalling only from an attached, suspended device
  assign remote_resume_o = wake_q & connect_state_o & port_suspend_i;
  always @(posedge clock_i) begin
    float_q <= ~float_q;
    wake_q <= wake_i;
  end
endmodule : urhps_usb_dev_model
`default_nettype wire

// ### sim/tb_usb_root_hub_port_status.sv
// self-checking bench for the root hub port status block
`timescale 1ns/1ps
`default_nettype none
`include "urhps_params.svh"
module tb_usb_root_hub_port_status;
  typedef struct packed {logic [31:0] m; logic [31:0] d; logic [1:0] r;} urhps_exp_s;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hub_overcurrent_i = 1'b0;
  logic normal_irq_i = 1'b0, ownership_change_i = 1'b0, power_event_irq_i = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic host_irq_line0_o, host_irq_line1_o, wakeup_enable_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, exp_irq;
  logic [31:0] s_axi_rdata, r;
  logic [1:0] connect_state_i, low_speed_attached_i, port_overcurrent_i, remote_resume_i;
  logic [1:0] port_power_o, port_reset_o, port_suspend_o, port_resume_o, port_enabled_o;
  logic [1:0] plug = 2'b00, ls = 2'b00, oc = 2'b00, wake = 2'b00, port_error_i = 2'b00;
  int fails = 0, checks_done = 0, cycles = 0;
  urhps_exp_s e;
  urhps_exp_s exp_r[$];
  logic [1:0] exp_b[$];

  // short counts keep reset and resume within a brief run
  urhps_root_hub #(.RESET_CYCLES(20), .RESUME_CYCLES(10)) urhps_root_hub_inst (
    .clock_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .connect_state_i, .low_speed_attached_i, .port_overcurrent_i,
    .hub_overcurrent_i, .port_error_i, .remote_resume_i, .normal_irq_i, .ownership_change_i,
    .power_event_irq_i, .port_power_o, .port_reset_o, .port_suspend_o, .port_resume_o,
    .port_enabled_o, .wakeup_enable_o, .host_irq_line0_o, .host_irq_line1_o);
  urhps_usb_dev_model urhps_usb_dev_model_inst (
    .clock_i, .plug_i(plug), .low_speed_i(ls), .overcurrent_i(oc), .wake_i(wake),
    .port_power_i(port_power_o), .port_suspend_i(port_suspend_o),
    .connect_state_o(connect_state_i), .low_speed_o(low_speed_attached_i),
    .overcurrent_o(port_overcurrent_i), .remote_resume_o(remote_resume_i));

  always #10 clock_i = ~clock_i;

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_pin(input string what, input logic [1:0] exp, input logic [1:0] got);
    cmp_word(what, {30'h0, exp}, {30'h0, got});
  endtask : cmp_pin

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a inside {8'h50, 8'h54, 8'h58, 8'h5c, 8'h60}) ? `URHPS_RESP_OKAY : `URHPS_RESP_SLVERR;
  endfunction : resp_of

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, ta, tw;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    exp_b.push_back(resp_of(a));
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clock_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clock_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw_ok = aw_ok | ta;
      w_ok = w_ok | tw;
    end
    while (!s_axi_bvalid) @(negedge clock_i);
    @(posedge clock_i);
    s_axi_bready <= 1'b0;
  endtask : wr

  // read with its expected word noted first; mask hides unsettled bits
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    exp_r.push_back('{m, d & m, resp_of(a)});
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clock_i); while (!s_axi_arready);
    @(posedge clock_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock_i); while (!s_axi_rvalid);
    @(posedge clock_i);
    s_axi_rready <= 1'b0;
  endtask : rd

  // sampled before the handshake edge, so no race with the slave
  always @(negedge clock_i) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_r.pop_front();
      cmp_word("rdata", e.d, s_axi_rdata & e.m);
      cmp_pin("rresp", e.r, s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready) cmp_pin("bresp", exp_b.pop_front(), s_axi_bresp);
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // a hang counts as a mismatch
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    r = $urandom(32'hf5761e0e);
    cyc(20);
    sys_rst_i <= 1'b0;
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h44, 32'h0);
    // global power mode, then per-port mode with port 2 masked
    wr(8'h50, 32'h10000);
    rd(8'h58, 32'h100);
    cmp_pin("power", 2'b11, port_power_o);
    wr(8'h50, 32'h1);
    rd(8'h50, 32'h0);
    cmp_pin("power", 2'b00, port_power_o);
    wr(`URHPS_OFF_CTRL, 32'h2);
    wr(`URHPS_OFF_MASK, 32'h2);
    wr(8'h50, 32'h10000);
    cmp_pin("power", 2'b01, port_power_o);
    wr(8'h58, 32'h100);
    rd(8'h58, 32'h100);
    wr(8'h58, 32'h200);
    wr(8'h58, 32'h0);
    rd(8'h58, 32'h0);
    $display("test power done");
    // attach, flags, refused commands on the unpowered port
    plug <= 2'b11;
    ls <= 2'b01;
    cyc(3);
    rd(8'h54, 32'h10301);
    wr(8'h54, 32'h0);
    rd(8'h54, 32'h10301);
    wr(8'h54, 32'h10000);
    rd(8'h54, 32'h301);
    wr(8'h58, 32'h10);
    rd(8'h58, 32'h10000);
    cmp_pin("reset", 2'b00, port_reset_o);
    wr(8'h58, 32'h10000);
    wr(8'h58, 32'h4);
    rd(8'h58, 32'h10000);
    // port reset, software disable, refused software enable
    wr(8'h54, 32'h10);
    rd(8'h54, 32'h311);
    cmp_pin("reset", 2'b01, port_reset_o);
    cyc(25);
    rd(8'h54, 32'h100303);
    wr(8'h54, 32'h100001);
    rd(8'h54, 32'h301);
    wr(8'h54, 32'h20002);
    rd(8'h54, 32'h301);
    $display("test reset done");
    // suspend, resume by command and by the device
    wr(8'h54, 32'h8);
    rd(8'h54, 32'h301);
    wr(8'h54, 32'h10);
    cyc(25);
    wr(8'h54, 32'h100004);
    rd(8'h54, 32'h307);
    cmp_pin("suspend", 2'b01, port_suspend_o);
    wr(8'h54, 32'h8);
    cyc(15);
    rd(8'h54, 32'h40303);
    wr(8'h54, 32'h40004);
    wake <= 2'b01;
    cyc(20);
    rd(8'h54, 32'h40303);
    wake <= 2'b00;
    // overcurrent on an enabled port
    oc <= 2'b11;
    cyc(3);
    rd(8'h54, 32'ha0309, 32'hfffbffff);
    oc <= 2'b00;
    cyc(3);
    wr(8'h54, 32'he0000);
    rd(8'h54, 32'h301);
    // port error, then unplug, each on an enabled port
    wr(8'h54, 32'h10);
    cyc(25);
    port_error_i <= 2'b01;
    cyc(3);
    rd(8'h54, 32'h120301);
    port_error_i <= 2'b00;
    wr(8'h54, 32'h120000);
    wr(8'h54, 32'h10);
    cyc(25);
    plug <= 2'b10;
    cyc(3);
    rd(8'h54, 32'h130100);
    // hub overcurrent, wakeup enable with random reserved bits
    hub_overcurrent_i <= 1'b1;
    cyc(3);
    rd(8'h50, 32'h2, 32'h2);
    wr(`URHPS_OFF_CTRL, 32'h6);
    rd(8'h50, 32'h0, 32'h2);
    hub_overcurrent_i <= 1'b0;
    r = $urandom();
    wr(8'h50, (r & 32'h7ffc7ffc) | 32'h8000);
    rd(8'h50, 32'h8000, 32'hfffdffff);
    cmp_pin("wake", 2'b01, {1'b0, wakeup_enable_o});
    wr(8'h50, 32'h80000000);
    rd(8'h50, 32'h0, 32'h80008000);
    $display("test status done");
    // every source mix on both routes
    for (int i = 0; i < 16; i++) begin
      wr(`URHPS_OFF_CTRL, {29'h0, 2'b11, i[3]});
      {normal_irq_i, ownership_change_i, power_event_irq_i} <= i[2:0];
      cyc(2);
      exp_irq = {i[0], i[2] | i[0] | (i[3] & i[1])};
      cmp_pin("irq", exp_irq, {host_irq_line1_o, host_irq_line0_o});
    end
    $display("test irq done");
    finish_test();
  end
endmodule : tb_usb_root_hub_port_status
`default_nettype wire
